// >>> lfctx_pkg.sv
// Shared constants, types and decode functions for the transmit flow control block.
package lfctx_pkg;
    localparam int DEF_BYTES = 4;
    localparam int NFC_CODE_W = 4;
    localparam int UFC_SIZE_W = 3;
    localparam int IDLE_CNT_W = 9;
    localparam int BEAT_CNT_W = 4;
    localparam int MAX_MSG_BYTES = 16;
    localparam logic [NFC_CODE_W-1:0] NFC_RESUME = 4'h0;
    localparam logic [NFC_CODE_W-1:0] NFC_MAX_FINITE = 4'h8;
    localparam logic [NFC_CODE_W-1:0] NFC_HALT = 4'hf;

    typedef enum logic [2:0] {
        LANE_IDLE,
        LANE_DATA,
        LANE_NFC,
        LANE_UFC_HDR,
        LANE_UFC_DATA
    } lfctx_lane_type;

    // Codes between the largest finite count and the halt code carry no meaning.
    function automatic logic code_reserved(input logic [NFC_CODE_W-1:0] c);
        code_reserved = (c > NFC_MAX_FINITE) && (c != NFC_HALT);
    endfunction

    // Finite idle counts double with each code step: code n asks for 2**n beats.
    function automatic logic [IDLE_CNT_W-1:0] idle_count(input logic [NFC_CODE_W-1:0] c);
        idle_count = '0;
        if (c != NFC_RESUME && c <= NFC_MAX_FINITE)
        begin
            idle_count = IDLE_CNT_W'(1) << c;
        end
    endfunction

    // Payload beats are the message length over the lane width, rounded up.
    function automatic logic [BEAT_CNT_W-1:0] ufc_beats(input logic [UFC_SIZE_W-1:0] ms, input int bytes);
        int len;
        len = 2 * (int'(ms) + 1);
        ufc_beats = BEAT_CNT_W'((len + bytes - 1) / bytes);
    endfunction
endpackage

// >>> lfctx_if.sv
// Interface joining the flow control core and the user application.
`timescale 1ns/1ps
interface lfctx_if #(parameter int BYTES = lfctx_pkg::DEF_BYTES);
    import lfctx_pkg::*;
    logic nfc_req;
    logic [NFC_CODE_W-1:0] idle_request_code;
    logic nfc_ack;
    logic ufc_req;
    logic [UFC_SIZE_W-1:0] ctrl_msg_size_code;
    logic ufc_ack;
    logic [BYTES*8-1:0] tx_tdata;
    logic tx_tvalid;
    logic tx_tlast;
    logic tx_tready;

    modport core (
        input nfc_req, idle_request_code, ufc_req, ctrl_msg_size_code,
        input tx_tdata, tx_tvalid, tx_tlast,
        output nfc_ack, ufc_ack, tx_tready
    );
    modport user (
        output nfc_req, idle_request_code, ufc_req, ctrl_msg_size_code,
        output tx_tdata, tx_tvalid, tx_tlast,
        input nfc_ack, ufc_ack, tx_tready
    );
endinterface

// >>> lfctx_core.sv
// Transmit flow control core: message insertion, partner throttling and lane output.
//
// Overview of operation
// - Flow control exists only on framing builds.
// - Idle code: resume, 2..256 beats, halt.
// - Halt sends no frame data until lifted; control and rate messages still go out.
// - User raises rate request with idle code.
// - User holds rate request until acknowledged.
// - No user data during a rate message.
// - Ready low the cycle after rate acknowledge.
// - Ready low until requested idles sent.
// - Completion mode throttles only between frames.
// - Control messages preempt frame data.
// - Size code gives length two(code+1) bytes.
// - User holds control request until acknowledged.
// - Payload starts cycle after control acknowledge.
// - Ready low while payload uses data bus.
// - Acknowledged control message runs uninterrupted.
// - User requests only with whole payload ready.
// - Payload beats: length over width, rounded up.
// - Header in acknowledge cycle, then payload beats.
// - Single-beat message drops ready two cycles.
`timescale 1ns/1ps
module lfctx_core #(
    parameter int BYTES = lfctx_pkg::DEF_BYTES,
    parameter bit FRAMING_IF = 1'b1
) (
    input wire logic i_clk,                                      // user clock
    input wire logic i_rst_b,                                    // async reset, active low
    lfctx_if.core bus,                                           // user transmit interface
    input wire logic i_completion_mode,                          // 1: throttle between frames only
    input wire logic i_rx_nfc_valid,                             // partner rate message arrived
    input wire logic [lfctx_pkg::NFC_CODE_W-1:0] i_rx_nfc_code,  // code of that message
    output lfctx_pkg::lfctx_lane_type o_lane_kind,               // kind of beat on the lane
    output logic [BYTES*8-1:0] o_lane_data,                      // lane beat content
    output logic o_lane_last,                                    // last data beat of a frame
    output logic o_halted                                        // partner halt in force
);
    import lfctx_pkg::*;

    logic nfc_ack;
    logic nfc_send;
    logic [NFC_CODE_W-1:0] nfc_code;
    logic ufc_ack;
    logic [BEAT_CNT_W-1:0] ufc_left;
    logic ufc_busy;
    logic next_nfc_ack;
    logic next_ufc_ack;
    logic in_frame;
    logic data_beat;
    logic pend_valid;
    logic [NFC_CODE_W-1:0] pend_code;
    logic apply_now;
    logic halt;
    logic [IDLE_CNT_W-1:0] idle_left;
    logic throttle;
    logic hold_gap;
    logic idle_beat;
    logic tready;

    assign ufc_busy = ufc_ack || (ufc_left != '0);
    assign throttle = halt || (idle_left != '0);

    // A control request wins over a rate request when both are pending.
    always_comb
    begin
        next_ufc_ack = FRAMING_IF && bus.ufc_req && !ufc_busy && !nfc_ack;
        next_nfc_ack = FRAMING_IF && bus.nfc_req && !nfc_ack && !nfc_send
            && !ufc_busy && !next_ufc_ack
            && !code_reserved(bus.idle_request_code);
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            nfc_ack <= 1'b0;
            nfc_send <= 1'b0;
            nfc_code <= '0;
        end
        else
        begin
            nfc_ack <= next_nfc_ack;
            nfc_send <= nfc_ack;
            if (next_nfc_ack)
            begin
                nfc_code <= bus.idle_request_code;
            end
        end
    end

    // Once acknowledged the beat counter runs down with nothing able to stop it.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ufc_ack <= 1'b0;
            ufc_left <= '0;
        end
        else
        begin
            ufc_ack <= next_ufc_ack;
            if (ufc_ack)
            begin
                ufc_left <= ufc_beats(bus.ctrl_msg_size_code, BYTES);
            end
            else if (ufc_left != '0)
            begin
                ufc_left <= ufc_left - BEAT_CNT_W'(1);
            end
        end
    end

    assign data_beat = bus.tx_tvalid && tready;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            in_frame <= 1'b0;
        end
        else if (data_beat)
        begin
            in_frame <= !bus.tx_tlast;
        end
    end

    // Partner requests wait here; a newer request replaces an older pending one.
    assign apply_now = pend_valid && (!i_completion_mode || !in_frame);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pend_valid <= 1'b0;
            pend_code <= '0;
        end
        else if (i_rx_nfc_valid && !code_reserved(i_rx_nfc_code))
        begin
            pend_valid <= 1'b1;
            pend_code <= i_rx_nfc_code;
        end
        else if (apply_now)
        begin
            pend_valid <= 1'b0;
        end
    end

    // Idles are counted only in beats that really go out as throttle idles.
    assign idle_beat = throttle && !ufc_busy && !nfc_send;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            halt <= 1'b0;
            idle_left <= '0;
        end
        else if (apply_now)
        begin
            halt <= (pend_code == NFC_HALT);
            idle_left <= idle_count(pend_code);
        end
        else if (idle_beat && idle_left != '0)
        begin
            idle_left <= idle_left - IDLE_CNT_W'(1);
        end
    end

    // In completion mode a new frame is held off so the pending idles land between frames.
    assign hold_gap = pend_valid && i_completion_mode && !in_frame;

    assign tready = FRAMING_IF && !ufc_busy && !nfc_send
        && !throttle && !hold_gap;
    assign bus.tx_tready = tready;
    assign bus.nfc_ack = nfc_ack;
    assign bus.ufc_ack = ufc_ack;
    assign o_halted = halt;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_lane_kind <= LANE_IDLE;
            o_lane_data <= '0;
            o_lane_last <= 1'b0;
        end
        else
        begin
            o_lane_last <= 1'b0;
            if (ufc_ack)
            begin
                o_lane_kind <= LANE_UFC_HDR;
                o_lane_data <= (BYTES*8)'(bus.ctrl_msg_size_code);
            end
            else if (ufc_left != '0)
            begin
                o_lane_kind <= LANE_UFC_DATA;
                o_lane_data <= bus.tx_tdata;
            end
            else if (nfc_send)
            begin
                o_lane_kind <= LANE_NFC;
                o_lane_data <= (BYTES*8)'(nfc_code);
            end
            else if (data_beat)
            begin
                o_lane_kind <= LANE_DATA;
                o_lane_data <= bus.tx_tdata;
                o_lane_last <= bus.tx_tlast;
            end
            else
            begin
                o_lane_kind <= LANE_IDLE;
                o_lane_data <= '0;
            end
        end
    end
endmodule

// >>> lfctx_user.sv
// User application end: issues rate and control messages and merges payload onto the data bus.
`timescale 1ns/1ps
module lfctx_user #(
    parameter int BYTES = lfctx_pkg::DEF_BYTES
) (
    input wire logic i_clk,                                                 // user clock
    input wire logic i_rst_b,                                               // async reset, active low
    lfctx_if.user bus,                                                      // core transmit interface
    input wire logic i_nfc_start,                                           // pulse: send rate message
    input wire logic [lfctx_pkg::NFC_CODE_W-1:0] i_nfc_code,                // idle code to send
    output logic o_nfc_busy,                                                // rate request pending
    input wire logic i_ufc_start,                                           // pulse: send control message
    input wire logic [lfctx_pkg::UFC_SIZE_W-1:0] i_ufc_size,                // size code
    input wire logic [lfctx_pkg::MAX_MSG_BYTES*8-1:0] i_ufc_payload,        // whole payload, byte 0 low
    output logic o_ufc_busy,                                                // control message in flight
    input wire logic [BYTES*8-1:0] i_data,                                  // frame data
    input wire logic i_data_valid,                                          // frame data valid
    input wire logic i_data_last,                                           // last beat of frame
    output logic o_data_ready                                               // frame data taken
);
    import lfctx_pkg::*;

    typedef enum logic [1:0] {
        U_IDLE,
        U_REQ,
        U_SEND
    } lfctx_ufc_state_type;

    lfctx_ufc_state_type state;
    logic nfc_req;
    logic [NFC_CODE_W-1:0] nfc_code;
    logic [UFC_SIZE_W-1:0] ufc_size;
    logic [MAX_MSG_BYTES*8-1:0] payload;
    logic [BEAT_CNT_W-1:0] left;

    // Reserved codes are dropped here rather than left to stall the core.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            nfc_req <= 1'b0;
            nfc_code <= '0;
        end
        else if (nfc_req)
        begin
            if (bus.nfc_ack)
            begin
                nfc_req <= 1'b0;
            end
        end
        else if (i_nfc_start && !code_reserved(i_nfc_code))
        begin
            nfc_req <= 1'b1;
            nfc_code <= i_nfc_code;
        end
    end

    // The whole payload is captured at start, so the transfer never has to pause.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= U_IDLE;
            ufc_size <= '0;
            payload <= '0;
            left <= '0;
        end
        else
        begin
            case (state)
                U_IDLE:
                begin
                    if (i_ufc_start)
                    begin
                        state <= U_REQ;
                        ufc_size <= i_ufc_size;
                        payload <= i_ufc_payload;
                    end
                end
                U_REQ:
                begin
                    if (bus.ufc_ack)
                    begin
                        state <= U_SEND;
                        left <= ufc_beats(ufc_size, BYTES);
                    end
                end
                U_SEND:
                begin
                    payload <= payload >> (BYTES*8);
                    left <= left - BEAT_CNT_W'(1);
                    if (left == BEAT_CNT_W'(1))
                    begin
                        state <= U_IDLE;
                    end
                end
                default:
                begin
                    state <= U_IDLE;
                end
            endcase
        end
    end

    assign bus.nfc_req = nfc_req;
    assign bus.idle_request_code = nfc_code;
    assign bus.ufc_req = (state == U_REQ);
    assign bus.ctrl_msg_size_code = ufc_size;
    assign bus.tx_tdata = (state == U_SEND) ? payload[BYTES*8-1:0] : i_data;
    assign bus.tx_tvalid = (state != U_SEND) && i_data_valid;
    assign bus.tx_tlast = i_data_last;
    assign o_data_ready = bus.tx_tready && (state != U_SEND);
    assign o_nfc_busy = nfc_req;
    assign o_ufc_busy = (state != U_IDLE);
endmodule

// >>> lfctx_properties.sv
// Interface checks for the transmit flow control block.
`timescale 1ns/1ps
module lfctx_properties #(
    parameter int BYTES = lfctx_pkg::DEF_BYTES
) (
    input wire logic i_clk, // user clock
    input wire logic i_rst_b, // reset, active low
    input wire logic nfc_req, // rate request
    input wire logic [lfctx_pkg::NFC_CODE_W-1:0] idle_request_code, // idle code
    input wire logic nfc_ack, // rate acknowledge
    input wire logic ufc_req, // control request
    input wire logic [lfctx_pkg::UFC_SIZE_W-1:0] ctrl_msg_size_code, // size code
    input wire logic ufc_ack, // control acknowledge
    input wire logic tx_tready // core ready
);
    import lfctx_pkg::*;
    logic [3:0] left;

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // Payload beats still owed after a control acknowledge.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            left <= 4'h0;
        else if (ufc_ack)
            left <= 4'((2 * (int'(ctrl_msg_size_code) + 1) + BYTES - 1) / BYTES);
        else if (left != 4'h0)
            left <= left - 4'h1;
    end

    a_nfc_gap: assert property (nfc_ack |=> !tx_tready) else $error("ready high after rate ack");
    a_nfc_pulse: assert property (nfc_ack |=> !nfc_ack) else $error("rate ack longer than one cycle");
    a_nfc_cause: assert property (nfc_ack |-> $past(nfc_req) &&
        ($past(idle_request_code) <= 4'h8 || $past(idle_request_code) == 4'hf))
        else $error("rate ack without valid request");
    a_ufc_cause: assert property (ufc_ack |-> $past(ufc_req)) else $error("control ack without request");
    a_ufc_hdr_gap: assert property (ufc_ack |-> !tx_tready ##1 !tx_tready)
        else $error("ready high in header or first beat");
    a_payload_gap: assert property (left != 4'h0 |-> !tx_tready) else $error("ready high during payload");
    a_ufc_unbroken: assert property (left != 4'h0 |-> !ufc_ack && !nfc_ack)
        else $error("message broken into");
    a_acks_apart: assert property (!(nfc_ack && ufc_ack)) else $error("both acks together");

    c_nfc: cover property (nfc_ack ##1 !tx_tready);
    c_ufc_long: cover property (ufc_ack && ctrl_msg_size_code == 3'h7);
    c_ufc_short: cover property (ufc_ack && ctrl_msg_size_code == 3'h0);
endmodule

// >>> test_link_flow_control_tx.sv
// Bench joining the core and user ends of the transmit flow control block.
`timescale 1ns/1ps
module test_link_flow_control_tx;
    import lfctx_pkg::*;
    localparam int BYTES = DEF_BYTES;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic cmode = 1'b0;
    logic rx_v = 1'b0;
    logic nfc_go = 1'b0;
    logic ufc_go = 1'b0;
    logic [3:0] code = 4'h0;
    logic [MAX_MSG_BYTES*8-1:0] pay = '0;
    logic [BYTES*8-1:0] dat = '0;
    logic dv = 1'b0;
    logic dl = 1'b0;
    lfctx_lane_type kind;
    logic [BYTES*8-1:0] ldat;
    logic llast, halted, nbusy, ubusy, dready;
    logic [31:0] seed = 32'h45;
    int errors = 0;
    int checks_done = 0;
    int n, j, k;

    lfctx_if #(.BYTES(BYTES)) bus ();
    lfctx_core #(.BYTES(BYTES)) i_lfctx_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus),
        .i_completion_mode(cmode), .i_rx_nfc_valid(rx_v), .i_rx_nfc_code(code), .o_lane_kind(kind),
        .o_lane_data(ldat), .o_lane_last(llast), .o_halted(halted));
    lfctx_user #(.BYTES(BYTES)) i_lfctx_user (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus), .i_nfc_start(nfc_go),
        .i_nfc_code(code), .o_nfc_busy(nbusy), .i_ufc_start(ufc_go), .i_ufc_size(code[2:0]), .i_ufc_payload(pay),
        .o_ufc_busy(ubusy), .i_data(dat), .i_data_valid(dv), .i_data_last(dl), .o_data_ready(dready));
    lfctx_properties #(.BYTES(BYTES)) i_lfctx_properties (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .nfc_req(bus.nfc_req), .idle_request_code(bus.idle_request_code), .nfc_ack(bus.nfc_ack),
        .ufc_req(bus.ufc_req), .ctrl_msg_size_code(bus.ctrl_msg_size_code), .ufc_ack(bus.ufc_ack),
        .tx_tready(bus.tx_tready));

    always #12.5 i_clk = ~i_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Only the bytes that belong to the message are compared in a part-filled last beat.
    function automatic logic [BYTES*8-1:0] msk(input int sz, input int b);
        int v;
        v = 2 * (sz + 1) - b * BYTES;
        msk = '1;
        if (v < BYTES)
            msk = (BYTES*8)'((64'h1 << (8 * v)) - 64'h1);
    endfunction

    task automatic test_done();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc();
        @(posedge i_clk);
        dat <= seed[BYTES*8-1:0];
        seed = xs(seed);
        #1;
    endtask

    // One-cycle start pulse: 0 partner message, 1 rate request, 2 control message.
    task automatic go(input int w, input logic [3:0] c);
        @(posedge i_clk);
        code <= c;
        pay <= {seed, ~seed, xs(seed), seed ^ 32'h00ff00ff};
        rx_v <= (w == 0);
        nfc_go <= (w == 1);
        ufc_go <= (w == 2);
        #1;
        @(posedge i_clk);
        {rx_v, nfc_go, ufc_go} <= 3'h0;
        #1;
    endtask

    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        dv <= 1'b1;
        cyc();
        for (k = 0; k < 10; k++)
        begin
            go(1, (k == 9) ? 4'hf : k[3:0]);
            chk(nbusy, 1'b1);
            for (n = 0; n < 20 && bus.nfc_ack !== 1'b1; n++) cyc();
            chk(bus.nfc_ack, 1'b1);
            cyc();
            chk(bus.tx_tready, 1'b0);
            chk(dready, 1'b0);
            chk(nbusy, 1'b0);
            cyc();
            chk(kind, LANE_NFC);
            chk(ldat, (k == 9) ? 4'hf : k[3:0]);
            cyc();
        end
        go(1, 4'h9);
        repeat (8)
        begin
            cyc();
            chk(bus.nfc_ack, 1'b0);
            chk(nbusy, 1'b0);
        end
        @(posedge i_clk);
        dv <= 1'b1;
        #1;
        for (k = 0; k < 8; k++)
        begin
            go(2, k[3:0]);
            chk(ubusy, 1'b1);
            for (n = 0; n < 20 && bus.ufc_ack !== 1'b1; n++) cyc();
            chk(bus.ufc_ack, 1'b1);
            chk(bus.tx_tready, 1'b0);
            cyc();
            chk(kind, LANE_UFC_HDR);
            chk(ldat, k[2:0]);
            for (j = 0; j < (2 * (k + 1) + BYTES - 1) / BYTES; j++)
            begin
                chk(bus.tx_tready, 1'b0);
                chk(dready, 1'b0);
                cyc();
                chk(kind, LANE_UFC_DATA);
                chk(ldat & msk(k, j), pay[j*BYTES*8 +: BYTES*8] & msk(k, j));
            end
            chk(bus.tx_tready, 1'b1);
            chk(dready, 1'b1);
            chk(ubusy, 1'b0);
            cyc();
        end
        for (k = 1; k < 9; k = k * 2)
        begin
            go(0, k[3:0]);
            cyc();
            for (j = 0; j < (1 << k); j++)
            begin
                chk(bus.tx_tready, 1'b0);
                cyc();
            end
            chk(bus.tx_tready, 1'b1);
        end
        go(0, 4'hf);
        repeat (2) cyc();
        repeat (20)
        begin
            cyc();
            chk(kind === LANE_DATA, 1'b0);
        end
        chk(halted, 1'b1);
        go(0, 4'h0);
        cyc();
        chk(bus.tx_tready, 1'b1);
        cyc();
        chk(halted, 1'b0);
        @(posedge i_clk);
        cmode <= 1'b1;
        #1;
        go(0, 4'h1);
        repeat (6)
        begin
            cyc();
            chk(bus.tx_tready, 1'b1);
        end
        // A reserved partner code must not replace the pending two-beat request.
        go(0, 4'h9);
        @(posedge i_clk);
        dl <= 1'b1;
        #1;
        @(posedge i_clk);
        {dl, dv} <= 2'h0;
        #1;
        chk(kind, LANE_DATA);
        chk(llast, 1'b1);
        chk(ldat, dat);
        for (n = 0; n < 4 && bus.tx_tready !== 1'b0; n++) cyc();
        chk(bus.tx_tready, 1'b0);
        repeat (2)
        begin
            cyc();
            chk(bus.tx_tready, 1'b0);
        end
        cyc();
        chk(bus.tx_tready, 1'b1);
        test_done();
    end

    initial
    begin
        #100us;
        errors++;
        test_done();
    end
endmodule
